// ---- include/epp_pkg.sv ----
package epp_pkg;

    // register offsets from the port base
    localparam logic [2:0] OFF_STATUS  = 3'h1;
    localparam logic [2:0] OFF_CONTROL = 3'h2;
    localparam logic [2:0] OFF_ADDR    = 3'h3;
    localparam logic [2:0] OFF_DATA0   = 3'h4;
    localparam logic [2:0] OFF_DATA3   = 3'h7;

    // control register fields; bits 6 and 7 are not stored
    localparam int         CTL_WIDTH   = 6;
    localparam int         CTL_STROBE  = 0;
    localparam int         CTL_AUTO_FEED_OUTPUT  = 1;
    localparam int         CTL_INIT    = 2;
    localparam int         CTL_SELIN   = 3;
    localparam int         CTL_IEN     = 4;
    localparam int         CTL_DIR     = 5;
    localparam logic [5:0] CTL_RESET   = 6'h00;

    // status register fields
    localparam int         STS_TIMEOUT = 0;
    localparam int         STS_ACK     = 6;
    localparam int         STS_BUSY    = 7;

    localparam logic [7:0] BYTE_RESET  = 8'h00;

    // watchdog
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         TIMEOUT_NS     = 10000;
    localparam int         TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;

    // request queue between host strobes and the cycle engine
    localparam int         FIFO_DEPTH  = 4;
    localparam int         CMD_WIDTH   = 2;
    localparam int         CMD_READ    = 1;
    localparam int         CMD_ADDR    = 0;

    // pin input filter
    localparam int         SYNC_WIDTH  = 23;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_WAIT_LOW = 3'h1,
        ST_STROBE   = 3'h3,
        ST_DONE     = 3'h2
    } cycle_state_t;

endpackage

// ---- hw/epp_parallel_port_cycles.sv ----
`timescale 1ns/1ps

// three-stage filter: a change counts once stages two and three agree
module pin_filter #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            level <= RESET_VAL;
        else
            level <= (stage3 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
    end
endmodule

module req_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
            if (pop)
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

module epp_parallel_port_cycles #(
    parameter int TIMEOUT_CYCLES = epp_pkg::TIMEOUT_CYCLES,
    parameter int FIFO_DEPTH     = epp_pkg::FIFO_DEPTH
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       epp_mode_sel,
    input  wire logic       epp_v19_sel,
    input  wire logic       config_register_one_bit3,
    input  wire logic [2:0] host_addr,
    input  wire logic       host_ior_n,
    input  wire logic       host_iow_n,
    input  wire logic [7:0] system_data_bus_in,
    output logic      [7:0] system_data_bus_out,
    output logic            system_data_bus_oe,
    output logic            iochrdy_out,
    output logic            iochrdy_oe,
    output logic            irq,
    input  wire logic [7:0] peripheral_data_lines_in,
    output logic      [7:0] peripheral_data_lines_out,
    output logic            peripheral_data_lines_oe,
    output logic            port_direction_output,
    input  wire logic       wait_n,
    input  wire logic       ack_n,
    output logic            strobe_write_n,
    output logic            auto_feed_datastb_n,
    output logic            init_n,
    output logic            select_addrstb_n
);
    localparam int WD_W = $clog2(TIMEOUT_CYCLES + 1);

    logic [epp_pkg::SYNC_WIDTH-1:0] pins_f;
    logic                           ior_f;
    logic                           iow_f;
    logic                           wait_f;
    logic                           ack_f;
    logic [2:0]                     addr_f;
    logic [7:0]                     wdata_f;
    logic [7:0]                     pd_f;

    pin_filter #(
        .WIDTH     (epp_pkg::SYNC_WIDTH),
        .RESET_VAL ({4'hf, 19'h00000})
    ) u_filter (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin     ({host_ior_n, host_iow_n, wait_n, ack_n, host_addr,
                   system_data_bus_in, peripheral_data_lines_in}),
        .level   (pins_f)
    );

    assign {ior_f, iow_f, wait_f, ack_f, addr_f, wdata_f, pd_f} = pins_f;

    logic [epp_pkg::CTL_WIDTH-1:0]  control;
    logic                           cycle_timeout_flag;
    logic [7:0]                     epp_address_port;
    logic [7:0]                     epp_data_port;
    logic [7:0]                     read_latch;
    logic                           ior_q;
    logic                           iow_q;
    logic                           ack_q;
    logic                           req_pend;
    logic [epp_pkg::CMD_WIDTH-1:0]  req_cmd;
    logic [epp_pkg::CMD_WIDTH-1:0]  cmd;
    logic                           fifo_in_ready;
    logic                           fifo_out_valid;
    logic [epp_pkg::CMD_WIDTH-1:0]  fifo_out_data;
    epp_pkg::cycle_state_t          state;
    logic [WD_W-1:0]                wd_cnt;
    logic                           wd_run;
    logic                           timeout;
    logic                           epp_hit;
    logic                           rd_start;
    logic                           wr_start;
    logic                           wr_end;
    logic                           host_active;
    logic                           in_cycle;
    logic                           cmd_read;
    logic                           strobing;
    logic                           ctl_strobe;
    logic                           ext_mode;

    assign epp_hit  = epp_mode_sel && (addr_f >= epp_pkg::OFF_ADDR);
    assign rd_start = !ior_f && ior_q;
    assign wr_start = !iow_f && iow_q;
    assign wr_end   = iow_f && !iow_q;
    assign in_cycle = (state != epp_pkg::ST_IDLE);
    assign strobing = (state == epp_pkg::ST_STROBE);
    assign ctl_strobe = control[epp_pkg::CTL_STROBE];
    assign ext_mode = !config_register_one_bit3;

    // in 1.9 a set direction bit turns any cycle into a read, unflagged
    assign cmd_read = cmd[epp_pkg::CMD_READ]
                   || (epp_v19_sel && control[epp_pkg::CTL_DIR]);
    assign host_active = cmd[epp_pkg::CMD_READ] ? !ior_f : !iow_f;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ior_q <= 1'b1;
            iow_q <= 1'b1;
            ack_q <= 1'b1;
        end
        else
        begin
            ior_q <= ior_f;
            iow_q <= iow_f;
            ack_q <= ack_f;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= control[epp_pkg::CTL_IEN] && ack_f && !ack_q;
    end

    // leading host strobe edge queues a cycle; in 1.9 ready stays low meanwhile
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            req_pend <= 1'b0;
            req_cmd  <= '0;
        end
        else if ((rd_start || wr_start) && epp_hit)
        begin
            req_pend <= 1'b1;
            req_cmd  <= {rd_start, addr_f == epp_pkg::OFF_ADDR};
        end
        else if (fifo_in_ready)
            req_pend <= 1'b0;
    end

    req_fifo #(
        .WIDTH (epp_pkg::CMD_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (req_pend),
        .in_ready  (fifo_in_ready),
        .in_data   (req_cmd),
        .out_valid (fifo_out_valid),
        .out_ready (!in_cycle),
        .out_data  (fifo_out_data)
    );

    // watchdog: 1.9 stops at wait high, 1.7 at host strobe end
    assign wd_run  = epp_v19_sel ? (state == epp_pkg::ST_WAIT_LOW || strobing) : strobing;
    assign timeout = wd_run && (wd_cnt == WD_W'(TIMEOUT_CYCLES));

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            wd_cnt <= '0;
        else if (wd_run && !timeout)
            wd_cnt <= wd_cnt + WD_W'(1);
        else if (!wd_run)
            wd_cnt <= '0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state <= epp_pkg::ST_IDLE;
            cmd   <= '0;
        end
        else
        begin
            case (state)
                epp_pkg::ST_IDLE:
                begin
                    if (fifo_out_valid)
                    begin
                        cmd   <= fifo_out_data;
                        state <= epp_v19_sel ? epp_pkg::ST_WAIT_LOW : epp_pkg::ST_STROBE;
                    end
                end
                epp_pkg::ST_WAIT_LOW:
                begin
                    if (timeout)
                        state <= epp_pkg::ST_DONE;
                    else if (!wait_f)
                        state <= epp_pkg::ST_STROBE;
                end
                epp_pkg::ST_STROBE:
                begin
                    if (timeout)
                        state <= epp_pkg::ST_DONE;
                    else if (epp_v19_sel && wait_f)
                        state <= epp_pkg::ST_DONE;
                    else if (!epp_v19_sel && !host_active)
                        state <= epp_pkg::ST_IDLE;
                end
                epp_pkg::ST_DONE:
                begin
                    if (!host_active)
                        state <= epp_pkg::ST_IDLE;
                end
                default:
                    state <= epp_pkg::ST_IDLE;
            endcase
        end
    end

    logic strobe_end;
    assign strobe_end = strobing && !timeout
                     && (epp_v19_sel ? wait_f : !host_active);

    // byte capture at the end of the strobe
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            epp_address_port <= epp_pkg::BYTE_RESET;
            epp_data_port    <= epp_pkg::BYTE_RESET;
            read_latch       <= epp_pkg::BYTE_RESET;
        end
        else if (strobe_end)
        begin
            if (cmd_read)
                read_latch <= pd_f;
            else if (cmd[epp_pkg::CMD_ADDR])
                epp_address_port <= wdata_f;
            else
                epp_data_port <= wdata_f;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            control <= epp_pkg::CTL_RESET;
        else if (wr_end && addr_f == epp_pkg::OFF_CONTROL)
            control <= wdata_f[epp_pkg::CTL_WIDTH-1:0];
    end

    // set wins over a same-cycle software clear
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            cycle_timeout_flag <= 1'b0;
        else if (timeout)
            cycle_timeout_flag <= 1'b1;
        else if (wr_end && addr_f == epp_pkg::OFF_STATUS && wdata_f[epp_pkg::STS_TIMEOUT])
            cycle_timeout_flag <= 1'b0;
    end

    // drive the host byte while a write cycle runs, hold it afterwards
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            peripheral_data_lines_out <= epp_pkg::BYTE_RESET;
        else if (in_cycle && !cmd_read && state != epp_pkg::ST_DONE)
            peripheral_data_lines_out <= wdata_f;
    end

    always_comb
    begin
        if (in_cycle && epp_v19_sel)
            port_direction_output = cmd_read && !ctl_strobe;
        else if (ext_mode)
            port_direction_output = control[epp_pkg::CTL_DIR];
        else
            port_direction_output = 1'b0;
    end

    assign peripheral_data_lines_oe = !port_direction_output;

    // shared pins: strobe/write, autofeed/data strobe, select/address strobe
    always_comb
    begin
        strobe_write_n      = !ctl_strobe;
        auto_feed_datastb_n = !control[epp_pkg::CTL_AUTO_FEED_OUTPUT];
        select_addrstb_n    = !control[epp_pkg::CTL_SELIN];
        if (in_cycle)
            strobe_write_n = !(!cmd_read || ctl_strobe);
        if (strobing && cmd[epp_pkg::CMD_ADDR])
            select_addrstb_n = 1'b0;
        if (strobing && !cmd[epp_pkg::CMD_ADDR])
            auto_feed_datastb_n = 1'b0;
    end

    assign init_n = control[epp_pkg::CTL_INIT];

    // open drain: enable pulls the ready line low
    assign iochrdy_out = 1'b0;

    always_comb
    begin
        if (epp_v19_sel)
            iochrdy_oe = req_pend || (fifo_out_valid && !in_cycle)
                      || state == epp_pkg::ST_WAIT_LOW || strobing;
        else
            iochrdy_oe = strobing && !wait_f;
    end

    // host read data: status and control live, epp ports from the latch
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            system_data_bus_out <= epp_pkg::BYTE_RESET;
        else if (!ior_f)
        begin
            case (addr_f)
                epp_pkg::OFF_STATUS:
                begin
                    system_data_bus_out <= epp_pkg::BYTE_RESET;
                    system_data_bus_out[epp_pkg::STS_TIMEOUT] <= cycle_timeout_flag;
                    system_data_bus_out[epp_pkg::STS_ACK]     <= ack_f;
                    system_data_bus_out[epp_pkg::STS_BUSY]    <= wait_f;
                end
                epp_pkg::OFF_CONTROL:
                    system_data_bus_out <= {2'b00, control};
                default:
                    system_data_bus_out <= read_latch;
            endcase
        end
    end

    assign system_data_bus_oe = !ior_f && (addr_f == epp_pkg::OFF_STATUS
                             || addr_f == epp_pkg::OFF_CONTROL || epp_hit);
endmodule

// ---- testbench/epp_port_checker_monitor.sv ----
`timescale 1ns/1ps

module epp_port_checker #(
    parameter int TIMEOUT_CYCLES = 1000
) (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       epp_mode_sel,
    input wire logic       epp_v19_sel,
    input wire logic [2:0] host_addr,
    input wire logic       host_iow_n,
    input wire logic       system_data_bus_oe,
    input wire logic       iochrdy_oe,
    input wire logic       irq,
    input wire logic       peripheral_data_lines_oe,
    input wire logic       port_direction_output,
    input wire logic       wait_n,
    input wire logic       ack_n,
    input wire logic       strobe_write_n,
    input wire logic       auto_feed_datastb_n,
    input wire logic       select_addrstb_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // slack covers the request queue ahead of the watchdog
    int unsigned hold_cnt;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !iochrdy_oe)
            hold_cnt <= 0;
        else
            hold_cnt <= hold_cnt + 1;
    end

    AST_READY_PULL: assert property ($fell(host_iow_n) && epp_mode_sel && epp_v19_sel
        && host_addr >= 3'h3 |-> ##[1:10] iochrdy_oe) else $error("ready not pulled");
    AST_V17_RELEASE: assert property ((!epp_v19_sel && wait_n)[*8] |-> !iochrdy_oe)
        else $error("ready held with wait high");
    AST_DIR_FLOAT: assert property (peripheral_data_lines_oe != port_direction_output)
        else $error("drive and direction disagree");
    AST_WATCHDOG: assert property (hold_cnt <= TIMEOUT_CYCLES + 8)
        else $error("cycle not aborted");
    AST_END_STROBE: assert property (epp_v19_sel && $fell(iochrdy_oe)
        |-> auto_feed_datastb_n && select_addrstb_n) else $error("strobe on at release");
    AST_WAIT_FIRST: assert property (epp_v19_sel && iochrdy_oe
        && ($fell(auto_feed_datastb_n) || $fell(select_addrstb_n))
        |-> !wait_n && !$past(wait_n, 3)) else $error("strobe before wait low");
    AST_NWRITE_DIR: assert property (epp_v19_sel && iochrdy_oe && !auto_feed_datastb_n
        |-> strobe_write_n == port_direction_output) else $error("write line vs direction");
    AST_NO_DECODE: assert property ((!epp_mode_sel && host_addr >= 3'h3)[*8]
        |-> !system_data_bus_oe) else $error("port decoded outside mode");
    AST_IRQ_EDGE: assert property (irq |-> $past(ack_n) && $past(ack_n, 2))
        else $error("irq without ack edge");
endmodule

bind epp_parallel_port_cycles epp_port_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .epp_mode_sel(epp_mode_sel), .epp_v19_sel(epp_v19_sel),
    .host_addr(host_addr), .host_iow_n(host_iow_n), .system_data_bus_oe(system_data_bus_oe),
    .iochrdy_oe(iochrdy_oe), .irq(irq), .peripheral_data_lines_oe(peripheral_data_lines_oe),
    .port_direction_output(port_direction_output), .wait_n(wait_n), .ack_n(ack_n),
    .strobe_write_n(strobe_write_n), .auto_feed_datastb_n(auto_feed_datastb_n),
    .select_addrstb_n(select_addrstb_n));

// ---- testbench/epp_peripheral_model.sv ----
`timescale 1ns/1ps

module epp_peripheral_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       datastb_n,
    input  wire logic       addrstb_n,
    input  wire logic       write_n,
    input  wire logic [7:0] pd_out,
    input  wire logic       pd_oe,
    input  wire logic       stall,
    input  wire logic       slow,
    input  wire logic [7:0] rd_byte,
    output logic      [7:0] pd_in,
    output logic            wait_n,
    output logic      [7:0] cap_byte,
    output logic            cap_addr,
    output logic            cap_write
);
    logic [4:0] cnt;
    wire        strb = !datastb_n || !addrstb_n;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt       <= 5'h00;
            wait_n    <= 1'b0;
            pd_in     <= 8'h00;
            cap_byte  <= 8'h00;
            cap_addr  <= 1'b0;
            cap_write <= 1'b0;
        end
        else if (strb)
        begin
            if (cnt == 5'h00)
            begin
                cap_addr  <= !addrstb_n;
                cap_write <= !write_n;
            end
            if (cnt != 5'h1f)
                cnt <= cnt + 5'h01;
            // byte taken on the same edge that wait goes high, so strobe end never races it
            if (!stall && cnt == (slow ? 5'h0c : 5'h02))
            begin
                wait_n <= 1'b1;
                if (pd_oe)
                    cap_byte <= pd_out;
            end
            pd_in <= pd_oe ? ~pd_in : rd_byte;
        end
        else
        begin
            cnt    <= 5'h00;
            wait_n <= 1'b0;
            pd_in  <= ~pd_in;
        end
    end
endmodule

// ---- testbench/test_epp_parallel_port_cycles.sv ----
`timescale 1ns/1ps

module test_epp_parallel_port_cycles;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       epp_mode_sel = 1'b1;
    logic       epp_v19_sel = 1'b1;
    logic       cfg3 = 1'b0;
    logic [2:0] host_addr = 3'h0;
    logic       host_ior_n = 1'b1;
    logic       host_iow_n = 1'b1;
    logic [7:0] sdi = 8'h00;
    logic       ack_n = 1'b1;
    logic       stall = 1'b0;
    logic       slow = 1'b0;
    logic [7:0] rd_byte = 8'h00;
    logic [7:0] sdo, pdo, pdi, cap_byte, d;
    logic       sd_oe, rdy_oe, irq, pd_oe, dir, wait_n, swr_n, dstb_n, init_n, astb_n;
    logic       cap_addr, cap_write, oe;
    int         n_fail = 0;
    int         check_count = 0;
    int         irq_cnt = 0;

    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (irq === 1'b1) irq_cnt++;

    // 1.7 watchdog spans the whole host strobe: the slow write needs about 25 cycles
    epp_parallel_port_cycles #(.TIMEOUT_CYCLES(40), .FIFO_DEPTH(4)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .epp_mode_sel(epp_mode_sel),
        .epp_v19_sel(epp_v19_sel), .config_register_one_bit3(cfg3), .host_addr(host_addr),
        .host_ior_n(host_ior_n), .host_iow_n(host_iow_n), .system_data_bus_in(sdi),
        .system_data_bus_out(sdo), .system_data_bus_oe(sd_oe), .iochrdy_out(),
        .iochrdy_oe(rdy_oe), .irq(irq), .peripheral_data_lines_in(pdi),
        .peripheral_data_lines_out(pdo), .peripheral_data_lines_oe(pd_oe),
        .port_direction_output(dir), .wait_n(wait_n), .ack_n(ack_n),
        .strobe_write_n(swr_n), .auto_feed_datastb_n(dstb_n), .init_n(init_n),
        .select_addrstb_n(astb_n));

    epp_peripheral_model peer (
        .clk_sys(clk_sys), .rst_n(rst_n), .datastb_n(dstb_n), .addrstb_n(astb_n),
        .write_n(swr_n), .pd_out(pdo), .pd_oe(pd_oe), .stall(stall), .slow(slow),
        .rd_byte(rd_byte), .pd_in(pdi), .wait_n(wait_n), .cap_byte(cap_byte),
        .cap_addr(cap_addr), .cap_write(cap_write));

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // holds the strobe until the ready line is released
    task automatic host_cycle(input logic [2:0] a, input logic [7:0] v, input logic rd);
        int i;
        @(negedge clk_sys);
        host_addr = a;
        sdi = v;
        if (rd) host_ior_n = 1'b0;
        else host_iow_n = 1'b0;
        repeat (12) @(negedge clk_sys);
        for (i = 0; i < 200 && rdy_oe !== 1'b0; i++) @(negedge clk_sys);
        if (i == 200)
        begin
            n_fail++;
            final_report();
        end
        repeat (2) @(negedge clk_sys);
        d = sdo;
        oe = sd_oe;
        host_ior_n = 1'b1;
        host_iow_n = 1'b1;
        repeat (12) @(negedge clk_sys);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        host_cycle(a, v, 1'b0);
    endtask

    task automatic rd(input logic [2:0] a);
        host_cycle(a, 8'h00, 1'b1);
    endtask

    task automatic pulse_ack;
        @(negedge clk_sys) ack_n = 1'b0;
        repeat (10) @(negedge clk_sys);
        ack_n = 1'b1;
        repeat (10) @(negedge clk_sys);
    endtask

    function automatic logic [7:0] pins();
        return {3'h0, swr_n, dstb_n, astb_n, init_n, dir};
    endfunction

    initial
    begin
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("reset pins", 8'h1c, pins());
        wr(epp_pkg::OFF_CONTROL, 8'hff);
        rd(epp_pkg::OFF_CONTROL);
        chk("control", 8'h3f, d);
        chk("idle pins", 8'h03, pins());
        cfg3 = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("printer dir", 8'h02, pins());
        cfg3 = 1'b0;
        pulse_ack();
        chk("irq on", 8'h01, 8'(irq_cnt));
        wr(epp_pkg::OFF_CONTROL, 8'h04);
        pulse_ack();
        chk("irq off", 8'h01, 8'(irq_cnt));
        $display("control and irq done");
        for (int a = 3; a <= 7; a++)
        begin
            wr(3'(a), 8'(8'h50 + a));
            chk("wr byte", 8'(8'h50 + a), cap_byte);
            chk("wr kind", {6'h00, a == 3, 1'b1}, {6'h00, cap_addr, cap_write});
            rd_byte = 8'(8'h90 + a);
            rd(3'(a));
            chk("rd byte", 8'(8'h90 + a), d);
            chk("rd kind", {6'h00, a == 3, 1'b0}, {6'h00, cap_addr, cap_write});
        end
        $display("epp 1.9 transfers done");
        wr(epp_pkg::OFF_CONTROL, 8'h21);
        rd(epp_pkg::OFF_DATA0);
        chk("forced write", 8'h01, {7'h00, cap_write});
        wr(epp_pkg::OFF_CONTROL, 8'h20);
        wr(epp_pkg::OFF_DATA0, 8'h77);
        chk("write as read", 8'h00, {7'h00, cap_write});
        wr(epp_pkg::OFF_CONTROL, 8'h04);
        $display("direction override done");
        for (int m = 1; m >= 0; m--)
        begin
            epp_v19_sel = 1'(m);
            stall = 1'b1;
            wr(epp_pkg::OFF_DATA0, 8'h66);
            stall = 1'b0;
            rd(epp_pkg::OFF_STATUS);
            chk("timeout set", 8'h01, d & 8'h01);
            wr(epp_pkg::OFF_STATUS, 8'h00);
            rd(epp_pkg::OFF_STATUS);
            chk("zero kept", 8'h01, d & 8'h01);
            wr(epp_pkg::OFF_STATUS, 8'h01);
            rd(epp_pkg::OFF_STATUS);
            chk("timeout clr", 8'h00, d & 8'h01);
        end
        $display("watchdog done");
        wr(epp_pkg::OFF_CONTROL, 8'h00);
        slow = 1'b1;
        wr(epp_pkg::OFF_DATA3, 8'h3c);
        chk("v17 byte", 8'h3c, cap_byte);
        rd(epp_pkg::OFF_STATUS);
        chk("v17 no timeout", 8'h00, d & 8'h01);
        slow = 1'b0;
        epp_mode_sel = 1'b0;
        rd(epp_pkg::OFF_DATA0);
        chk("no decode", 8'h00, {7'h00, oe});
        $display("epp 1.7 and decode done");
        final_report();
    end
endmodule
